// ==== logic/spi_port_pkg.sv ====
// Purpose: constants, types and state layout for the serial peripheral port
// Assumes: 250 MHz system clock, 32-bit AXI4-Lite register access, 8-bit registers
// Notes: register offsets are word indices, byte address is four times the index
`default_nettype none

package spi_port_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;

  // Register word indices and byte addresses
  localparam logic [7:0] IDX_CONTROL = 8'h0D;
  localparam logic [7:0] IDX_STATUS = 8'h0E;
  localparam logic [7:0] IDX_DATA = 8'h0F;
  localparam logic [7:0] IDX_PINS = 8'h10;
  localparam logic [7:0] ADDR_CONTROL = 8'(IDX_CONTROL * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
  localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 4);
  localparam logic [7:0] ADDR_PINS = 8'(IDX_PINS * 4);

  // Decoded register selects
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CTRL = 3'h1;
  localparam logic [2:0] SEL_STAT = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_PINS = 3'h4;

  // Control register fields
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_ORDER = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLOCK_IDLE_LEVEL = 3;
  localparam int CTL_CLOCK_SAMPLE_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status register fields
  localparam int STS_DONE = 7;
  localparam int STS_WRITE_COLLISION_FLAG = 6;
  localparam logic [5:0] STS_RESERVED = 6'h00;

  // Pin register: direction bits 3..0, output values at PIN_VAL + pin
  localparam int PIN_MOSI = 0;
  localparam int PIN_MISO = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SS = 3;
  localparam int PIN_VAL = 4;
  localparam logic [7:0] PINS_RESET = 8'h00;

  // Bit rates and SCK half periods in system clocks, rounded up
  localparam int unsigned RATE0_HZ = 3_000_000;
  localparam int unsigned RATE1_HZ = 750_000;
  localparam int unsigned RATE2_HZ = 187_500;
  localparam int unsigned RATE3_HZ = 93_750;
  localparam logic [10:0] HALF0 = 11'((CLK_HZ + 2 * RATE0_HZ - 1) / (2 * RATE0_HZ));
  localparam logic [10:0] HALF1 = 11'((CLK_HZ + 2 * RATE1_HZ - 1) / (2 * RATE1_HZ));
  localparam logic [10:0] HALF2 = 11'((CLK_HZ + 2 * RATE2_HZ - 1) / (2 * RATE2_HZ));
  localparam logic [10:0] HALF3 = 11'((CLK_HZ + 2 * RATE3_HZ - 1) / (2 * RATE3_HZ));

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } xfer_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pins;
    logic done;
    logic write_collision_flag;
    logic arm_done;
    logic arm_write_collision_flag;
    logic [7:0] rxbuf;
    logic [7:0] sh;
    logic dout;
    logic sck;
    xfer_state_t st;
    logic [3:0] bitcnt;
    logic [10:0] divcnt;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic ss_s1;
    logic ss_s2;
    logic mosi_s1;
    logic mosi_s2;
    logic miso_s1;
    logic miso_s2;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

`default_nettype wire

// ==== logic/spi_port.sv ====
// Purpose: byte-wide full-duplex serial port, master or slave, behind AXI4-Lite
// Assumes: SCK, MOSI, MISO and SS pins are asynchronous and pass two flip-flops
// Notes: slave SCK must stay well below a quarter of MCLK; pins split into I, O, OE
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

module spi_port (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // AXI4-Lite write address and data
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // CPU interrupt hookup
  input wire logic GLOBAL_IE,
  input wire logic VECTOR_TAKEN,
  output logic IRQ,
  // Serial clock pin
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  // Master out pin
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  // Master in pin
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  // Slave select pin
  input wire logic SS_I,
  output logic SS_O,
  output logic SS_OE
);

  spi_port_pkg::state_t r;
  spi_port_pkg::state_t n;

  logic en;
  logic mst;
  logic clock_idle_level;
  logic clock_sample_phase;
  logic lsb;
  logic slv_sel;
  logic demote;
  logic wr_go;
  logic rd_go;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic dwr;
  logic daccess;
  logic lead_ev;
  logic trail_ev;
  logic smp_ev;
  logic chg_ev;
  logic rx_bit;
  logic [7:0] sh_new;
  logic [3:0] cnt_new;
  logic done_set;
  logic write_collision_flag_set;

  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == spi_port_pkg::ADDR_CONTROL) begin
      return spi_port_pkg::SEL_CTRL;
    end else if (a == spi_port_pkg::ADDR_STATUS) begin
      return spi_port_pkg::SEL_STAT;
    end else if (a == spi_port_pkg::ADDR_DATA) begin
      return spi_port_pkg::SEL_DATA;
    end else if (a == spi_port_pkg::ADDR_PINS) begin
      return spi_port_pkg::SEL_PINS;
    end else begin
      return spi_port_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [10:0] half_count(input logic [1:0] rate);
    case (rate)
      2'h0: return spi_port_pkg::HALF0;
      2'h1: return spi_port_pkg::HALF1;
      2'h2: return spi_port_pkg::HALF2;
      default: return spi_port_pkg::HALF3;
    endcase
  endfunction

  function automatic logic out_bit(input logic [7:0] d, input logic lsb_first);
    return lsb_first ? d[0] : d[7];
  endfunction

  assign en = r.ctrl[spi_port_pkg::CTL_ENABLE];
  assign mst = r.ctrl[spi_port_pkg::CTL_MASTER];
  assign clock_idle_level = r.ctrl[spi_port_pkg::CTL_CLOCK_IDLE_LEVEL];
  assign clock_sample_phase = r.ctrl[spi_port_pkg::CTL_CLOCK_SAMPLE_PHASE];
  assign lsb = r.ctrl[spi_port_pkg::CTL_ORDER];

  // Bus handshakes
  assign AWREADY = !r.aw_hold && !r.bvalid;
  assign WREADY = !r.w_hold && !r.bvalid;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = !r.rvalid;
  assign RVALID = r.rvalid;
  assign RRESP = r.rresp;
  assign RDATA = {24'h000000, r.rdata};

  assign IRQ = r.done && r.ctrl[spi_port_pkg::CTL_IRQ_EN] && GLOBAL_IE;

  always_comb begin
    n = r;
    done_set = 1'b0;
    write_collision_flag_set = 1'b0;
    lead_ev = 1'b0;
    trail_ev = 1'b0;

    // Pin synchronisers
    n.sck_s1 = SCK_I;
    n.sck_s2 = r.sck_s1;
    n.sck_s3 = r.sck_s2;
    n.ss_s1 = SS_I;
    n.ss_s2 = r.ss_s1;
    n.mosi_s1 = MOSI_I;
    n.mosi_s2 = r.mosi_s1;
    n.miso_s1 = MISO_I;
    n.miso_s2 = r.miso_s1;

    // Write address and data may arrive in either order
    if (AWVALID && AWREADY) begin
      n.aw_hold = 1'b1;
      n.awaddr = AWADDR;
    end
    if (WVALID && WREADY) begin
      n.w_hold = 1'b1;
      n.wdata = WDATA[7:0];
      n.wstrb0 = WSTRB[0];
    end
    if (r.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    wr_go = r.aw_hold && r.w_hold;
    wr_sel = reg_sel(r.awaddr);
    dwr = wr_go && r.wstrb0 && (wr_sel == spi_port_pkg::SEL_DATA);
    if (wr_go) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wr_sel == spi_port_pkg::SEL_NONE) ? spi_port_pkg::RESP_SLVERR :
                spi_port_pkg::RESP_OKAY;
      if (r.wstrb0 && wr_sel == spi_port_pkg::SEL_CTRL) begin
        n.ctrl = r.wdata;
      end else if (r.wstrb0 && wr_sel == spi_port_pkg::SEL_PINS) begin
        n.pins = r.wdata;
      end
    end

    // Read channel
    rd_go = ARVALID && !r.rvalid;
    rd_sel = reg_sel(ARADDR);
    if (r.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp = spi_port_pkg::RESP_OKAY;
      if (rd_sel == spi_port_pkg::SEL_CTRL) begin
        n.rdata = r.ctrl;
      end else if (rd_sel == spi_port_pkg::SEL_STAT) begin
        n.rdata = {r.done, r.write_collision_flag, spi_port_pkg::STS_RESERVED};
      end else if (rd_sel == spi_port_pkg::SEL_DATA) begin
        n.rdata = r.rxbuf;
      end else if (rd_sel == spi_port_pkg::SEL_PINS) begin
        n.rdata = r.pins;
      end else begin
        n.rdata = 8'h00;
        n.rresp = spi_port_pkg::RESP_SLVERR;
      end
    end

    // Flag clearing: status read arms, later data access clears
    daccess = (wr_go && wr_sel == spi_port_pkg::SEL_DATA) ||
              (rd_go && rd_sel == spi_port_pkg::SEL_DATA);
    if (daccess) begin
      if (r.arm_write_collision_flag) begin
        n.write_collision_flag = 1'b0;
        n.done = 1'b0;
      end
      if (r.arm_done) begin
        n.done = 1'b0;
      end
      n.arm_done = 1'b0;
      n.arm_write_collision_flag = 1'b0;
    end
    if (rd_go && rd_sel == spi_port_pkg::SEL_STAT) begin
      n.arm_done = r.done;
      n.arm_write_collision_flag = r.write_collision_flag;
    end
    if (VECTOR_TAKEN) begin
      n.done = 1'b0;
    end

    // Clock edges: generated as master, detected on the pin as slave
    slv_sel = en && !mst && !r.ss_s2;
    demote = en && mst && !r.pins[spi_port_pkg::PIN_SS] && !r.ss_s2;
    if (en && mst && r.st == spi_port_pkg::ST_SHIFT) begin
      if (r.divcnt == half_count(r.ctrl[spi_port_pkg::CTL_RATE_HI:spi_port_pkg::CTL_RATE_LO])
          - 11'h001) begin
        n.divcnt = 11'h000;
        n.sck = !r.sck;
        lead_ev = (r.sck == clock_idle_level);
        trail_ev = (r.sck != clock_idle_level);
      end else begin
        n.divcnt = r.divcnt + 11'h001;
      end
    end else if (slv_sel && r.sck_s2 != r.sck_s3) begin
      lead_ev = (r.sck_s2 != clock_idle_level);
      trail_ev = (r.sck_s2 == clock_idle_level);
    end

    // Shift engine shared by both modes
    smp_ev = clock_sample_phase ? trail_ev : lead_ev;
    chg_ev = clock_sample_phase ? lead_ev : trail_ev;
    rx_bit = mst ? r.miso_s2 : r.mosi_s2;
    sh_new = r.sh;
    cnt_new = r.bitcnt;
    if (r.st == spi_port_pkg::ST_SHIFT || lead_ev) begin
      n.st = spi_port_pkg::ST_SHIFT;
      if (smp_ev) begin
        // Received bit enters at the end opposite the one the sent bit left
        sh_new = lsb ? {rx_bit, r.sh[7:1]} : {r.sh[6:0], rx_bit};
        cnt_new = r.bitcnt + 4'h1;
      end
      if (chg_ev) begin
        n.dout = out_bit(r.sh, lsb);
      end
      n.sh = sh_new;
      n.bitcnt = cnt_new;
      if (trail_ev && cnt_new == spi_port_pkg::BITS_PER_BYTE) begin
        n.st = spi_port_pkg::ST_IDLE;
        n.bitcnt = 4'h0;
        n.rxbuf = sh_new;
        done_set = 1'b1;
      end
    end

    // Data register write: load when idle, flag a collision otherwise
    if (dwr) begin
      if (r.st == spi_port_pkg::ST_SHIFT) begin
        write_collision_flag_set = 1'b1;
        n.sh = sh_new;
      end else begin
        n.sh = r.wdata;
        if (!clock_sample_phase) begin
          n.dout = out_bit(r.wdata, lsb);
        end
        if (en && mst) begin
          n.st = spi_port_pkg::ST_SHIFT;
          n.bitcnt = 4'h0;
          n.divcnt = 11'h000;
        end
      end
    end

    // Disable, deselect and demotion abort the transfer
    if (!en) begin
      n.st = spi_port_pkg::ST_IDLE;
      n.bitcnt = 4'h0;
    end else if (!mst && r.ss_s2) begin
      n.st = spi_port_pkg::ST_IDLE;
      n.bitcnt = 4'h0;
    end
    if (demote) begin
      n.ctrl[spi_port_pkg::CTL_MASTER] = 1'b0;
      n.st = spi_port_pkg::ST_IDLE;
      n.bitcnt = 4'h0;
      done_set = 1'b1;
    end
    if (n.st != spi_port_pkg::ST_SHIFT || !n.ctrl[spi_port_pkg::CTL_MASTER]) begin
      n.sck = n.ctrl[spi_port_pkg::CTL_CLOCK_IDLE_LEVEL];
      n.divcnt = 11'h000;
    end

    // Hardware set wins over any clear in the same cycle
    if (done_set) begin
      n.done = 1'b1;
    end
    if (write_collision_flag_set) begin
      n.write_collision_flag = 1'b1;
    end
  end

  // Pin direction overrides and output values
  always_comb begin
    MOSI_OE = r.pins[spi_port_pkg::PIN_MOSI];
    MISO_OE = r.pins[spi_port_pkg::PIN_MISO];
    SCK_OE = r.pins[spi_port_pkg::PIN_SCK];
    SS_OE = r.pins[spi_port_pkg::PIN_SS];
    MOSI_O = r.pins[spi_port_pkg::PIN_VAL + spi_port_pkg::PIN_MOSI];
    MISO_O = r.pins[spi_port_pkg::PIN_VAL + spi_port_pkg::PIN_MISO];
    SCK_O = r.pins[spi_port_pkg::PIN_VAL + spi_port_pkg::PIN_SCK];
    SS_O = r.pins[spi_port_pkg::PIN_VAL + spi_port_pkg::PIN_SS];
    if (en && mst) begin
      MISO_OE = 1'b0;
      MOSI_O = r.dout;
      SCK_O = r.sck;
    end else if (en) begin
      MOSI_OE = 1'b0;
      SCK_OE = 1'b0;
      SS_OE = 1'b0;
      MISO_OE = r.pins[spi_port_pkg::PIN_MISO] && !r.ss_s2;
      MISO_O = r.dout;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  start_clock_a: assert property (
    (dwr && r.st == spi_port_pkg::ST_IDLE && en && mst && !demote)
    |=> (r.st == spi_port_pkg::ST_SHIFT) [*8])
    else $error("master data write did not start a transfer");

  done_after_byte_a: assert property (
    ($past(r.st) == spi_port_pkg::ST_SHIFT && r.st == spi_port_pkg::ST_IDLE &&
     $past(en && mst) && !$past(demote) && !$past(dwr))
    |-> r.done && r.sck == clock_idle_level)
    else $error("master transfer ended without done flag and idle clock");

  sck_idle_level_a: assert property (
    (en && mst && r.st == spi_port_pkg::ST_IDLE) |-> (SCK_O == clock_idle_level))
    else $error("serial clock not at idle level");

  master_pins_a: assert property (
    (en && mst) |-> !MISO_OE && MOSI_OE == r.pins[spi_port_pkg::PIN_MOSI] &&
                    SCK_O == r.sck)
    else $error("master pin directions wrong");

  slave_pins_a: assert property (
    (en && !mst) |-> !MOSI_OE && !SCK_OE && !SS_OE && (!MISO_OE || !r.ss_s2))
    else $error("slave pin directions wrong");

  demote_master_a: assert property (
    demote |=> !r.ctrl[spi_port_pkg::CTL_MASTER] && r.done &&
               r.st == spi_port_pkg::ST_IDLE)
    else $error("low select did not demote master");

  slave_abort_a: assert property (
    (en && !mst && r.ss_s2) |=> r.st == spi_port_pkg::ST_IDLE && r.bitcnt == 4'h0)
    else $error("deselected slave kept its transfer");

  collision_flag_a: assert property (
    (dwr && r.st == spi_port_pkg::ST_SHIFT) |=> r.write_collision_flag && r.sh == $past(sh_new))
    else $error("collision write not flagged");

  rx_hold_a: assert property (
    $changed(r.rxbuf) |-> r.done && $past(r.st) == spi_port_pkg::ST_SHIFT)
    else $error("receive buffer changed without a completed byte");

  vector_clear_a: assert property (
    (VECTOR_TAKEN && !done_set) |=> !r.done)
    else $error("vector taken did not clear done flag");

  irq_gate_a: assert property (
    IRQ |-> r.done && r.ctrl[spi_port_pkg::CTL_IRQ_EN] && GLOBAL_IE)
    else $error("interrupt without its enables");

endmodule // spi_port

`default_nettype wire

// ==== dv/spi_peer.sv ====
// Purpose: behavioural serial peripheral on the far side of the port in master mode
// Assumes: selected while sel_n is low, mode and order given by the bench
// Notes: a released data line shows the inverse of its last bit, never a held value
`timescale 1ns/100ps
`default_nettype none

module spi_peer (
  // Link pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // Mode and data
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  logic [7:0] sh;
  logic o;

  // Reload on select so each frame swaps whole bytes
  always @(negedge sel_n) begin
    sh = tx;
    o = lsb ? tx[0] : tx[7];
  end

  always @(sck) begin
    if (!sel_n) begin
      if ((sck !== clock_idle_level) ^ clock_sample_phase) begin
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        if (clock_sample_phase) sh = lsb ? sh >> 1 : sh << 1;
      end else begin
        if (!clock_sample_phase) sh = lsb ? sh >> 1 : sh << 1;
        o = lsb ? sh[0] : sh[7];
      end
    end
  end

  assign miso = sel_n ? ~o : o;
endmodule // spi_peer

`default_nettype wire

// ==== dv/spi_port_tb.sv ====
// Purpose: self-checking bench for the serial port behind AXI4-Lite
// Assumes: as master the port talks to spi_peer, as slave the bench drives the link
// Notes: a cycle watchdog cuts a hung run short
`timescale 1ns/100ps
`default_nettype none

module spi_port_tb;
  localparam logic [7:0] A_CTL = spi_port_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_STS = spi_port_pkg::ADDR_STATUS;
  localparam logic [7:0] A_DAT = spi_port_pkg::ADDR_DATA;
  localparam logic [7:0] A_PIN = spi_port_pkg::ADDR_PINS;
  logic mclk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, gie = 1'h1, vt = 1'h0;
  logic b_sck = 1'h0, b_mosi = 1'h0, b_ss = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irq, p_miso, p_clock_idle_level, p_clock_sample_phase, p_lsb;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic [7:0] p_tx, p_rx, got;
  wire sck_w = sck_oe ? sck_o : b_sck;
  wire mosi_w = mosi_oe ? mosi_o : b_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  wire ss_w = ss_oe ? ss_o : b_ss;
  int n_mismatch = 0, checked = 0, cyc = 0, edges = 0;

  spi_port i_spi_port (
    .MCLK(mclk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .GLOBAL_IE(gie),
    .VECTOR_TAKEN(vt), .IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE(miso_oe), .SS_I(ss_w), .SS_O(ss_o), .SS_OE(ss_oe)
  );

  spi_peer i_spi_peer (
    .sck(sck_w), .mosi(mosi_w), .sel_n(ss_w), .miso(p_miso), .clock_idle_level(p_clock_idle_level),
    .clock_sample_phase(p_clock_sample_phase), .lsb(p_lsb), .tx(p_tx), .rx(p_rx)
  );

  always #2 mclk = ~mclk;
  always @(sck_w) edges++;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out;
    $display("Counts: %0d checked, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= {24'h0, d};
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      ta |= awready;
      tw |= wready;
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!(ta && tw));
    do @(posedge mclk); while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge mclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge mclk); while (rvalid !== 1'h1);
    rv = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  task automatic t_regs;
    rd(A_CTL);
    chk("ctl reset", 32'h0, rv);
    wr(A_CTL, 8'h2F);
    rd(A_CTL);
    chk("ctl rw", 32'h2F, rv);
    wr(A_STS, 8'hFF);
    rd(A_STS);
    chk("sts read", 32'h0, rv);
    wr(8'h00, 8'h55);
    chk("wr unmapped", 2'h2, resp);
    rd(8'h00);
    chk("rd unmapped", 2'h2, resp);
    $display("register test done");
  endtask

  // Master transfer against the peer in the mode that ctl selects
  task automatic t_xfer(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] ptx,
                        input int h);
    int n;
    wr(A_PIN, 8'h8D);
    wr(A_CTL, ctl);
    p_clock_idle_level = ctl[3];
    p_clock_sample_phase = ctl[2];
    p_lsb = ctl[5];
    p_tx = ptx;
    wr(A_PIN, 8'h0D);
    chk("sck idle", ctl[3], sck_w);
    edges = 0;
    wr(A_DAT, tx);
    n = 0;
    while (irq !== 1'h1) begin
      @(posedge mclk);
      n++;
    end
    chk("rate", 1'h1, n >= 16 * h - 4 && n <= 16 * h + 2);
    repeat (2 * h) @(posedge mclk);
    chk("sck edges", 16, edges);
    chk("sck rest", ctl[3], sck_w);
    chk("peer rx", tx, p_rx);
    rd(A_STS);
    chk("done", 8'h80, rv);
    rd(A_DAT);
    chk("rx", ptx, rv);
    rd(A_STS);
    chk("done clr", 8'h00, rv);
    $display("transfer test done");
  endtask

  task automatic t_coll;
    wr(A_PIN, 8'h8D);
    wr(A_CTL, 8'hD0);
    p_clock_idle_level = 1'h0;
    p_clock_sample_phase = 1'h0;
    p_lsb = 1'h0;
    p_tx = 8'h5A;
    wr(A_PIN, 8'h0D);
    wr(A_DAT, 8'h93);
    repeat (100) @(posedge mclk);
    wr(A_DAT, 8'h0F);
    while (irq !== 1'h1) @(posedge mclk);
    chk("coll tx", 8'h93, p_rx);
    gie <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("irq mask", 1'h0, irq);
    gie <= 1'h1;
    vt <= 1'h1;
    @(posedge mclk);
    vt <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("irq vec", 1'h0, irq);
    rd(A_STS);
    chk("write_collision_flag", 8'h40, rv);
    rd(A_DAT);
    chk("coll rx", 8'h5A, rv);
    rd(A_STS);
    chk("write_collision_flag clr", 8'h00, rv);
    $display("collision test done");
  endtask

  task automatic t_off;
    wr(A_PIN, 8'h8D);
    wr(A_CTL, 8'h90);
    edges = 0;
    wr(A_DAT, 8'h77);
    repeat (800) @(posedge mclk);
    chk("off edges", 0, edges);
    rd(A_STS);
    chk("off done", 8'h00, rv);
    $display("disabled test done");
  endtask

  task automatic t_demote;
    wr(A_PIN, 8'h05);
    b_ss <= 1'h1;
    wr(A_CTL, 8'h50);
    repeat (3) @(posedge mclk);
    chk("sck out", 1'h1, sck_oe);
    chk("miso in", 1'h0, miso_oe);
    b_ss <= 1'h0;
    repeat (8) @(posedge mclk);
    chk("sck dir", 1'h0, sck_oe);
    chk("mosi dir", 1'h0, mosi_oe);
    rd(A_CTL);
    chk("demoted", 8'h40, rv);
    rd(A_STS);
    chk("demote done", 8'h80, rv);
    rd(A_DAT);
    b_ss <= 1'h1;
    $display("demotion test done");
  endtask

  // Bench as link master: mode 0, MSB first, 32 ns clock only inside the frame
  task automatic frame(input logic [7:0] d, input int nb);
    logic [7:0] s;
    s = d;
    got = 8'h00;
    @(posedge mclk);
    b_ss <= 1'h0;
    b_mosi <= s[7];
    repeat (4) @(posedge mclk);
    chk("miso on", 1'h1, miso_oe);
    for (int i = 0; i < nb; i++) begin
      b_sck <= 1'h1;
      got = {got[6:0], miso_w};
      repeat (4) @(posedge mclk);
      b_sck <= 1'h0;
      s = s << 1;
      b_mosi <= s[7];
      repeat (4) @(posedge mclk);
    end
    b_ss <= 1'h1;
    b_mosi <= ~b_mosi;
    repeat (8) @(posedge mclk);
    chk("miso off", 1'h0, miso_oe);
  endtask

  task automatic t_slave;
    wr(A_PIN, 8'h07);
    wr(A_DAT, 8'h96);
    frame(8'h3C, 8);
    chk("slave tx", 8'h96, got);
    chk("slave sck", 1'h0, sck_oe);
    chk("slave mosi", 1'h0, mosi_oe);
    rd(A_STS);
    chk("slave done", 8'h80, rv);
    rd(A_DAT);
    chk("slave rx", 8'h3C, rv);
    frame(8'hC5, 4);
    rd(A_STS);
    chk("abort flag", 8'h00, rv);
    rd(A_DAT);
    chk("abort rx", 8'h3C, rv);
    $display("slave test done");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_xfer(8'hD0, 8'h1E, 8'h6B, spi_port_pkg::HALF0);
    t_xfer(8'hF5, 8'h35, 8'hD2, spi_port_pkg::HALF1);
    t_xfer(8'hDA, 8'h4C, 8'h17, spi_port_pkg::HALF2);
    t_xfer(8'hFF, 8'hE8, 8'h29, spi_port_pkg::HALF3);
    t_coll();
    t_off();
    t_demote();
    t_slave();
    close_out();
  end
endmodule // spi_port_tb

`default_nettype wire
